// ==== common/wdt_pkg.sv ====
package wdt_pkg;

    // ==========================================
    // register byte offsets
    localparam logic [11:0] OFFSET_CONFIGURATION = 12'h000;
    localparam logic [11:0] OFFSET_SERVICE = 12'h004;
    localparam logic [11:0] OFFSET_STATE = 12'h008;
    localparam logic [11:0] OFFSET_REVISION = 12'h3FC;

    // ==========================================
    // configuration, service and state register field positions
    localparam int KEY_MSB = 31;
    localparam int KEY_LSB = 24;
    localparam int BAN_MSB = 22;
    localparam int BAN_LSB = 18;
    localparam int CLOCK_SELECT_BIT = 17;
    localparam int CLOCK_ON_BIT = 16;
    localparam int TIMEOUT_MSB = 12;
    localparam int TIMEOUT_LSB = 8;
    localparam int CALIBRATION_BIT = 7;
    localparam int LOCK_BIT = 3;
    localparam int MODE_BIT = 2;
    localparam int OFF_AFTER_BIT = 1;
    localparam int ENABLE_BIT = 0;
    localparam int SERVICE_BIT = 0;
    localparam int CLEARED_BIT = 1;
    localparam int WINDOW_BIT = 0;

    // ==========================================
    // key values and reset values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [31:0] CONFIGURATION_RESET = 32'h00010080;
    localparam logic [31:0] STATE_RESET = 32'h00000003;
    // timeout select forced by the auto-start fuse: 2^18 cycles, far above 100 ms on the rc source
    localparam logic [4:0] AUTO_TIMEOUT_SELECT = 5'h11;

    // ==========================================
    // revision register, values are arbitrary
    localparam logic [11:0] MODULE_VERSION = 12'h101;
    localparam logic [3:0] MODULE_VARIANT = 4'h0;
    localparam int VERSION_MSB = 11;
    localparam int VARIANT_LSB = 16;
    localparam int VARIANT_MSB = 19;

    // ==========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================
    // keyed write sequencer
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b01,
        KEY_ARMED = 2'b10
    } key_state_t;

    localparam int COUNTER_WIDTH = 34;

endpackage

// ==== design/windowed_watchdog_timer.sv ====
`timescale 1ns/1ps

// Summary of operation
// - mode bit one selects window mode: ban period then servicing period.
// - mode bit cannot change while the watchdog is enabled.
// - window timeout is 2^(ban+1) plus 2^(timeout+1) count ticks, ban first.
// - valid service during the ban period fires a watchdog reset and clears counter.
// - valid service in servicing period clears counter, ban period starts again.
// - accepted configuration write clears the counter without any watchdog reset.
// - counter reaching the timeout clears it and fires a watchdog reset.
// - with count clock off, an enable one-to-zero write never shows in read-back.
// - auto-start fuse: enabled, basic mode, rc source, timeout above 100 ms.
// - watchdog reset with calibration done clear reruns calibration then sets it.
// - any other reset always runs calibration, setting calibration done afterwards.
// - lock bit one ignores later configuration writes until any reset.
// - configuration needs keyed writes 0x55 then 0xAA; key reads zero.
// - service register write-only, same key sequence; service bit one clears counter.
// - clock select zero picks rc oscillator, one picks slow crystal.
// - count clock on bit zero stops the count clock, one runs it.
// - off-after-reset one disables after watchdog reset unless the fuse is set with calibration done clear; zero keeps it enabled.
// - enable read-back changes only once synchronised to the count clock, except a watchdog reset with off-after-reset one and no fuse hold clears it at once.
// - cleared flag drops on service write, rises when counter clear completes.
// - window flag reads zero in ban period and one in servicing period.
// - revision register read-only: version in low twelve bits, variant above.
// - mode bit zero selects basic mode, timeout 2^(timeout+1) count ticks.
// - service counts only if the second keyed write keeps service bit one.
module windowed_watchdog_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // count clock sources, one-cycle enable pulses
    input wire logic internal_rc_oscillator_tick,
    input wire logic slow_crystal_oscillator_tick,
    // fuse and flash calibration
    input wire logic auto_start_fuse,
    input wire logic calibration_complete,
    output logic calibration_start,
    // watchdog reset request
    output logic watchdog_reset
);

    // ==========================================
    // state
    logic aw_held;
    logic w_held;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [4:0] ban_select;
    logic count_clock_select;
    logic count_clock_on;
    logic [4:0] timeout_select;
    logic calibration_done;
    logic configuration_lock;
    logic window_mode;
    logic off_after_watchdog_reset;
    logic enable_request;
    logic enable_active;
    logic calibration_busy;
    logic boot_pending;
    logic clear_pending;
    logic counter_cleared;
    logic [wdt_pkg::COUNTER_WIDTH-1:0] counter;
    wdt_pkg::key_state_t cfg_key;
    wdt_pkg::key_state_t svc_key;
    logic [23:0] cfg_first_value;
    logic svc_first_bit;

    // ==========================================
    // combinational
    logic wr_do;
    logic wr_full;
    logic wr_mapped;
    logic cfg_write;
    logic svc_write;
    logic cfg_accept;
    logic svc_accept;
    logic count_tick;
    logic in_ban;
    logic timeout_hit;
    logic ban_violation;
    logic wd_fire;
    logic fuse_hold;
    logic [wdt_pkg::COUNTER_WIDTH-1:0] ban_length;
    logic [wdt_pkg::COUNTER_WIDTH-1:0] timeout_length;
    logic [wdt_pkg::COUNTER_WIDTH-1:0] total_length;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [7:0] wr_key;

    assign wr_do = aw_held && w_held && !bvalid;
    assign wr_full = (wr_strb == 4'hF);
    assign wr_key = wr_data[wdt_pkg::KEY_MSB:wdt_pkg::KEY_LSB];
    assign wr_mapped = (wr_addr == wdt_pkg::OFFSET_CONFIGURATION) || (wr_addr == wdt_pkg::OFFSET_SERVICE)
        || (wr_addr == wdt_pkg::OFFSET_STATE) || (wr_addr == wdt_pkg::OFFSET_REVISION);
    // partial-strobe writes cannot carry a whole key, so they are dropped
    assign cfg_write = wr_do && wr_full && (wr_addr == wdt_pkg::OFFSET_CONFIGURATION);
    assign svc_write = wr_do && wr_full && (wr_addr == wdt_pkg::OFFSET_SERVICE);

    // second keyed write completes the sequence: unchanged payload for configuration, service bit one in both writes for service
    assign cfg_accept = cfg_write && (cfg_key == wdt_pkg::KEY_ARMED) && (wr_key == wdt_pkg::KEY_SECOND)
        && (wr_data[23:0] == cfg_first_value) && !configuration_lock;
    assign svc_accept = svc_write && (svc_key == wdt_pkg::KEY_ARMED) && (wr_key == wdt_pkg::KEY_SECOND)
        && svc_first_bit && wr_data[wdt_pkg::SERVICE_BIT] && counter_cleared;

    assign count_tick = (count_clock_select ? slow_crystal_oscillator_tick
        : internal_rc_oscillator_tick) && count_clock_on;

    // six-bit shift amount, a select of 31 must shift by 32 and not wrap to 0
    assign ban_length = wdt_pkg::COUNTER_WIDTH'(1) << (6'(ban_select) + 6'h01);
    assign timeout_length = wdt_pkg::COUNTER_WIDTH'(1) << (6'(timeout_select) + 6'h01);
    assign total_length = window_mode ? (ban_length + timeout_length) : timeout_length;
    assign in_ban = window_mode && (counter < ban_length);
    assign timeout_hit = enable_active && (counter >= total_length);
    assign ban_violation = enable_active && svc_accept && in_ban;
    assign wd_fire = timeout_hit || ban_violation;
    // fuse keeps the unit alive across a watchdog reset while calibration is pending
    assign fuse_hold = auto_start_fuse && !calibration_done;

    // ==========================================
    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 12'h000;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= wdt_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                wr_addr <= {awaddr[11:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_do) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_mapped ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ==========================================
    // axi4-lite read channel
    always_comb begin
        next_rdata = 32'h00000000;
        next_rresp = wdt_pkg::RESP_OKAY;
        if ({araddr[11:2], 2'b00} == wdt_pkg::OFFSET_CONFIGURATION) begin
            // key field always reads zero
            next_rdata[wdt_pkg::BAN_MSB:wdt_pkg::BAN_LSB] = ban_select;
            next_rdata[wdt_pkg::CLOCK_SELECT_BIT] = count_clock_select;
            next_rdata[wdt_pkg::CLOCK_ON_BIT] = count_clock_on;
            next_rdata[wdt_pkg::TIMEOUT_MSB:wdt_pkg::TIMEOUT_LSB] = timeout_select;
            next_rdata[wdt_pkg::CALIBRATION_BIT] = calibration_done;
            next_rdata[wdt_pkg::LOCK_BIT] = configuration_lock;
            next_rdata[wdt_pkg::MODE_BIT] = window_mode;
            next_rdata[wdt_pkg::OFF_AFTER_BIT] = off_after_watchdog_reset;
            next_rdata[wdt_pkg::ENABLE_BIT] = enable_active;
        end else if ({araddr[11:2], 2'b00} == wdt_pkg::OFFSET_SERVICE) begin
            next_rdata = 32'h00000000;
        end else if ({araddr[11:2], 2'b00} == wdt_pkg::OFFSET_STATE) begin
            next_rdata[wdt_pkg::CLEARED_BIT] = counter_cleared;
            next_rdata[wdt_pkg::WINDOW_BIT] = !in_ban;
        end else if ({araddr[11:2], 2'b00} == wdt_pkg::OFFSET_REVISION) begin
            next_rdata[wdt_pkg::VERSION_MSB:0] = wdt_pkg::MODULE_VERSION;
            next_rdata[wdt_pkg::VARIANT_MSB:wdt_pkg::VARIANT_LSB] = wdt_pkg::MODULE_VARIANT;
        end else begin
            next_rresp = wdt_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= wdt_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================
    // key sequencers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_key <= wdt_pkg::KEY_IDLE;
            cfg_first_value <= 24'h000000;
        end else if (cfg_write) begin
            // any write other than a first key breaks the sequence
            cfg_first_value <= wr_data[23:0];
            case (cfg_key)
                wdt_pkg::KEY_IDLE: begin
                    cfg_key <= (wr_key == wdt_pkg::KEY_FIRST) ? wdt_pkg::KEY_ARMED : wdt_pkg::KEY_IDLE;
                end
                wdt_pkg::KEY_ARMED: begin
                    cfg_key <= (wr_key == wdt_pkg::KEY_FIRST) ? wdt_pkg::KEY_ARMED : wdt_pkg::KEY_IDLE;
                end
                default: begin
                    cfg_key <= wdt_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            svc_key <= wdt_pkg::KEY_IDLE;
            svc_first_bit <= 1'b0;
        end else if (svc_write) begin
            svc_first_bit <= wr_data[wdt_pkg::SERVICE_BIT];
            case (svc_key)
                wdt_pkg::KEY_IDLE: begin
                    svc_key <= (wr_key == wdt_pkg::KEY_FIRST) ? wdt_pkg::KEY_ARMED : wdt_pkg::KEY_IDLE;
                end
                wdt_pkg::KEY_ARMED: begin
                    svc_key <= (wr_key == wdt_pkg::KEY_FIRST) ? wdt_pkg::KEY_ARMED : wdt_pkg::KEY_IDLE;
                end
                default: begin
                    svc_key <= wdt_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // configuration fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ban_select <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::BAN_MSB:wdt_pkg::BAN_LSB];
            count_clock_select <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::CLOCK_SELECT_BIT];
            count_clock_on <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::CLOCK_ON_BIT];
            timeout_select <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::TIMEOUT_MSB:wdt_pkg::TIMEOUT_LSB];
            configuration_lock <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::LOCK_BIT];
            window_mode <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::MODE_BIT];
            off_after_watchdog_reset <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::OFF_AFTER_BIT];
            enable_request <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::ENABLE_BIT];
            boot_pending <= 1'b1;
        end else if (boot_pending) begin
            // fuse level caught on the first edge after release
            boot_pending <= 1'b0;
            if (auto_start_fuse) begin
                enable_request <= 1'b1;
                window_mode <= 1'b0;
                count_clock_select <= 1'b0;
                count_clock_on <= 1'b1;
                timeout_select <= wdt_pkg::AUTO_TIMEOUT_SELECT;
            end
        end else if (wd_fire) begin
            configuration_lock <= 1'b0;
            if (off_after_watchdog_reset && !fuse_hold) begin
                enable_request <= 1'b0;
            end
        end else if (cfg_accept) begin
            ban_select <= wr_data[wdt_pkg::BAN_MSB:wdt_pkg::BAN_LSB];
            count_clock_select <= wr_data[wdt_pkg::CLOCK_SELECT_BIT];
            count_clock_on <= wr_data[wdt_pkg::CLOCK_ON_BIT];
            timeout_select <= wr_data[wdt_pkg::TIMEOUT_MSB:wdt_pkg::TIMEOUT_LSB];
            configuration_lock <= wr_data[wdt_pkg::LOCK_BIT];
            if (!enable_active && !enable_request) begin
                window_mode <= wr_data[wdt_pkg::MODE_BIT];
            end
            off_after_watchdog_reset <= wr_data[wdt_pkg::OFF_AFTER_BIT];
            enable_request <= wr_data[wdt_pkg::ENABLE_BIT];
        end
    end

    // read-back follows the request on a live count tick; a watchdog reset with off-after-reset one and no fuse hold clears it at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_active <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::ENABLE_BIT];
        end else if (wd_fire && off_after_watchdog_reset && !fuse_hold) begin
            enable_active <= 1'b0;
        end else if (count_tick) begin
            enable_active <= enable_request;
        end
    end

    // ==========================================
    // flash calibration handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            calibration_done <= wdt_pkg::CONFIGURATION_RESET[wdt_pkg::CALIBRATION_BIT];
            calibration_busy <= 1'b0;
            calibration_start <= 1'b0;
        end else begin
            calibration_start <= 1'b0;
            if (boot_pending) begin
                calibration_start <= 1'b1;
                calibration_busy <= 1'b1;
            end else if (wd_fire && !calibration_done) begin
                calibration_start <= 1'b1;
                calibration_busy <= 1'b1;
            end else if (calibration_busy && calibration_complete) begin
                calibration_busy <= 1'b0;
                calibration_done <= 1'b1;
            end else if (cfg_accept) begin
                calibration_done <= wr_data[wdt_pkg::CALIBRATION_BIT];
            end
        end
    end

    // ==========================================
    // counter and service
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter <= '0;
        end else if (wd_fire || cfg_accept) begin
            counter <= '0;
        end else if (clear_pending && count_tick) begin
            counter <= '0;
        end else if (enable_active && count_tick) begin
            counter <= counter + wdt_pkg::COUNTER_WIDTH'(1);
        end
    end

    // clearing waits for a count tick, so the flag shows the delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_cleared <= wdt_pkg::STATE_RESET[wdt_pkg::CLEARED_BIT];
            clear_pending <= 1'b0;
        end else if (wd_fire || cfg_accept) begin
            counter_cleared <= 1'b1;
            clear_pending <= 1'b0;
        end else if (svc_accept) begin
            counter_cleared <= 1'b0;
            clear_pending <= 1'b1;
        end else if (clear_pending && count_tick) begin
            counter_cleared <= 1'b1;
            clear_pending <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= wd_fire;
        end
    end

endmodule

// ==== verification/wdt_chk.sv ====
`timescale 1ns/1ps

module wdt_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [11:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // watchdog outputs
    input wire logic calibration_start,
    input wire logic watchdog_reset
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==========================================
    // bus answers
    bresp_holds_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer changed before bready");
    write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("no write answer two cycles after address and data");
    write_blocks_a: assert property (bvalid |-> !awready && !wready)
        else $error("write channel open while answer pending");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("no read answer one cycle after address");
    rdata_holds_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed before rready");
    // ==========================================
    // register contents and pulses
    key_reads_zero_a: assert property (arvalid && arready && araddr == wdt_pkg::OFFSET_CONFIGURATION
        |=> rdata[31:24] == 8'h00) else $error("key field read back non-zero");
    revision_value_a: assert property (arvalid && arready && araddr == wdt_pkg::OFFSET_REVISION
        |=> rdata == {12'h000, wdt_pkg::MODULE_VARIANT, 4'h0, wdt_pkg::MODULE_VERSION})
        else $error("revision register value wrong");
    reset_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("watchdog reset longer than one cycle");
    cal_pulse_a: assert property (calibration_start |=> !calibration_start)
        else $error("calibration request longer than one cycle");
endmodule

bind windowed_watchdog_timer wdt_chk i_wdt_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .calibration_start(calibration_start),
    .watchdog_reset(watchdog_reset)
);

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
    // ==========================================
    // signals
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, rc_tick, xtal_tick, cal_start, cal_done, wdt_rst, fuse;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data, rnd;
    logic [31:0] fires = 32'h00000000;
    logic [31:0] cals = 32'h00000000;
    logic [1:0] bresp, rresp, last_resp;
    int n_errors = 0;
    int compares = 0;
    integer seed;

    windowed_watchdog_timer i_windowed_watchdog_timer (
        .aclk(aclk), .aresetn(aresetn), .awprot(3'h0), .arprot(3'h0), .wstrb(4'hF),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .internal_rc_oscillator_tick(rc_tick), .slow_crystal_oscillator_tick(xtal_tick),
        .auto_start_fuse(fuse), .calibration_complete(cal_done),
        .calibration_start(cal_start), .watchdog_reset(wdt_rst)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // calibration engine answers one cycle after its request
    always @(posedge aclk) begin
        cal_done <= cal_start;
        xtal_tick <= 1'($random(seed)); // noise, rc source stays selected
        // outputs are unknown before the first reset edge
        if (aresetn) begin
            fires <= fires + {31'h0, wdt_rst};
            cals <= cals + {31'h0, cal_start};
        end
    end

    // ==========================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic give_up(input bit done);
        if (!done) begin
            n_errors++;
            end_sim();
        end
    endtask

    // ==========================================
    // bus master, bready and rready stay high throughout
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge aclk);
            done = bvalid;
            last_resp = bresp;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        give_up(done);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bit done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge aclk);
            done = rvalid;
            last_resp = rresp;
            rd_data = rdata;
            if (arready)
                arvalid <= 1'b0;
        end
        give_up(done);
        check(rd_data, exp);
    endtask

    task automatic cf(input logic [31:0] exp);
        rd(wdt_pkg::OFFSET_CONFIGURATION, exp);
    endtask

    task automatic st(input logic [31:0] exp);
        rd(wdt_pkg::OFFSET_STATE, exp);
    endtask

    task automatic cfg(input logic [23:0] v);
        wr(wdt_pkg::OFFSET_CONFIGURATION, {wdt_pkg::KEY_FIRST, v});
        wr(wdt_pkg::OFFSET_CONFIGURATION, {wdt_pkg::KEY_SECOND, v});
    endtask

    task automatic svc(input logic [23:0] second);
        wr(wdt_pkg::OFFSET_SERVICE, {wdt_pkg::KEY_FIRST, 24'h000001});
        wr(wdt_pkg::OFFSET_SERVICE, {wdt_pkg::KEY_SECOND, second});
    endtask

    // count ticks two cycles apart, then let the fire pulse land
    task automatic tk(input int n);
        repeat (n) begin
            rc_tick <= 1'b1;
            @(posedge aclk);
            rc_tick <= 1'b0;
            @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask

    // ==========================================
    // main sequence
    initial begin
        seed = 32'hC05D3D99;
        {aresetn, awvalid, wvalid, arvalid, rc_tick, fuse} = 6'h00;
        {awaddr, araddr, wdata} = '0;
        {bready, rready} = 2'h3;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cf(wdt_pkg::CONFIGURATION_RESET);
        st(wdt_pkg::STATE_RESET);
        wr(wdt_pkg::OFFSET_REVISION, 32'hFFFFFFFF);
        check({30'h0, last_resp}, {30'h0, wdt_pkg::RESP_OKAY});
        rd(wdt_pkg::OFFSET_REVISION, {12'h000, wdt_pkg::MODULE_VARIANT, 4'h0, wdt_pkg::MODULE_VERSION});
        rd(12'h010, 32'h00000000);
        check({30'h0, last_resp}, {30'h0, wdt_pkg::RESP_SLVERR});
        check(cals, 32'h1);
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            wr(wdt_pkg::OFFSET_CONFIGURATION, {wdt_pkg::KEY_FIRST, rnd[23:0]});
            if (i[0])
                wr(wdt_pkg::OFFSET_CONFIGURATION, {wdt_pkg::KEY_SECOND, rnd[23:0] ^ 24'h000001});
            else
                wr(wdt_pkg::OFFSET_CONFIGURATION, {4'h1, rnd[27:0]});
            cf(wdt_pkg::CONFIGURATION_RESET);
        end
        // basic mode, eight-tick timeout
        cfg(24'h010281);
        cf(32'h00010280);
        tk(1);
        cf(32'h00010281);
        svc(24'h000000);
        st(32'h00000003);
        svc(24'h000001);
        st(32'h00000001);
        tk(1);
        st(32'h00000003);
        tk(6);
        check(fires, 32'h0);
        tk(3);
        check(fires, 32'h1);
        cf(32'h00010281);
        cfg(24'h010285);
        cf(32'h00010281);
        cfg(24'h000280);
        tk(1);
        cf(32'h00000281);
        cfg(24'h010280);
        tk(1);
        cf(32'h00010280);
        // window mode, four-tick ban then four-tick window
        cfg(24'h050184);
        cfg(24'h050185);
        tk(1);
        st(32'h00000002);
        svc(24'h000001);
        repeat (4) @(posedge aclk);
        check(fires, 32'h2);
        tk(5);
        st(32'h00000003);
        svc(24'h000001);
        st(32'h00000001);
        tk(7);
        check(fires, 32'h2);
        tk(2);
        check(fires, 32'h3);
        cfg(24'h050107);
        tk(9);
        check(fires, 32'h4);
        check(cals, 32'h2);
        cf(32'h00050186);
        cfg(24'h050188);
        cfg(24'h010080);
        cf(32'h00050188);
        // second release with the fuse set: basic mode, rc source, long timeout
        aresetn <= 1'b0;
        fuse <= 1'b1;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rnd = {wdt_pkg::CONFIGURATION_RESET[31:13], wdt_pkg::AUTO_TIMEOUT_SELECT, wdt_pkg::CONFIGURATION_RESET[7:0]};
        cf(rnd);
        tk(1);
        cf(rnd | 32'h00000001);
        check(cals, 32'h3);
        end_sim();
    end
endmodule
